// ==== mie_irq_enable.sv ====
// Interrupt enable and masking block with its AXI4-Lite register slave.
`timescale 1ns/1ps

// Notes on behaviour
// - Underflow flag reaches Tx only with both enables.
// - Tx line follows master enable and summary flag.
// - Master enable low keeps Tx line low.
// - Control frame flag gated by bit 14, master.
// - Bus error flag gated by bit 11, master.
module mie_irq_enable (
   // Clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // AXI4-Lite write address channel
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data channel
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response channel
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address channel
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data channel
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Event pulses from the MAC datapath
   input wire logic tx_underflow_event,
   input wire logic ctrl_frame_event,
   input wire logic rx_bus_error_event,
   // Interrupt lines to the CPU
   output logic tx_irq,
   output logic rx_irq
);

   ////////////////////////////////////////////////////////////////////////
   // Register bus state.
   logic awready_q, awready_d;
   logic wready_q, wready_d;
   logic aw_have_q, aw_have_d;
   logic w_have_q, w_have_d;
   logic [7:0] awaddr_q, awaddr_d;
   logic [31:0] wdata_q, wdata_d;
   logic [3:0] wstrb_q, wstrb_d;
   logic bvalid_q, bvalid_d;
   logic [1:0] bresp_q, bresp_d;
   logic arready_q, arready_d;
   logic rvalid_q, rvalid_d;
   logic [31:0] rdata_q, rdata_d;
   logic [1:0] rresp_q, rresp_d;

   // Register contents and interrupt lines.
   logic [31:0] enable_q, enable_d;
   logic [mie_pkg::NUM_FLAGS-1:0] flags_q, flags_d;
   logic tx_irq_q, tx_irq_d;
   logic rx_irq_q, rx_irq_d;

   logic [mie_pkg::NUM_FLAGS-1:0] flag_event;
   logic [mie_pkg::NUM_FLAGS-1:0] flag_clear;
   logic [31:0] status_view;
   logic [31:0] byte_mask;
   logic do_write;
   logic tx_summary;

   assign flag_event[mie_pkg::FLAG_TX_UNDERFLOW] = tx_underflow_event;
   assign flag_event[mie_pkg::FLAG_CTRL_FRAME] = ctrl_frame_event;
   assign flag_event[mie_pkg::FLAG_RX_BUS_ERROR] = rx_bus_error_event;

   assign do_write = aw_have_q && w_have_q && !bvalid_q;
   assign byte_mask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
                       {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

   ////////////////////////////////////////////////////////////////////////
   // Write channels: address and data are taken in either order.
   always_comb begin
      awready_d = awready_q;
      wready_d = wready_q;
      aw_have_d = aw_have_q;
      w_have_d = w_have_q;
      awaddr_d = awaddr_q;
      wdata_d = wdata_q;
      wstrb_d = wstrb_q;
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      if (s_axi_awvalid && awready_q) begin
         aw_have_d = 1'b1;
         awaddr_d = s_axi_awaddr;
         awready_d = 1'b0;
      end
      if (s_axi_wvalid && wready_q) begin
         w_have_d = 1'b1;
         wdata_d = s_axi_wdata;
         wstrb_d = s_axi_wstrb;
         wready_d = 1'b0;
      end
      if (do_write) begin
         aw_have_d = 1'b0;
         w_have_d = 1'b0;
         bvalid_d = 1'b1;
         if (awaddr_q[7:mie_pkg::ADDR_LSB] ==
             mie_pkg::ADDR_ENABLE[7:mie_pkg::ADDR_LSB] ||
             awaddr_q[7:mie_pkg::ADDR_LSB] ==
             mie_pkg::ADDR_STATUS[7:mie_pkg::ADDR_LSB]) begin
            bresp_d = mie_pkg::RESP_OKAY;
         end else begin
            bresp_d = mie_pkg::RESP_SLVERR;
         end
      end
      if (bvalid_q && s_axi_bready) begin
         bvalid_d = 1'b0;
         awready_d = 1'b1;
         wready_d = 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         awready_q <= 1'b1;
         wready_q <= 1'b1;
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= 2'h0;
      end else begin
         awready_q <= awready_d;
         wready_q <= wready_d;
         aw_have_q <= aw_have_d;
         w_have_q <= w_have_d;
         awaddr_q <= awaddr_d;
         wdata_q <= wdata_d;
         wstrb_q <= wstrb_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read channel: one read at a time, answered the cycle after taking.
   always_comb begin
      status_view = 32'h0000_0000;
      for (int i = 0; i < mie_pkg::NUM_FLAGS; i++) begin
         status_view[mie_pkg::FLAG_BIT[i]] = flags_q[i];
      end
      status_view[mie_pkg::BIT_TX_MASTER] = tx_summary;
      arready_d = arready_q;
      rvalid_d = rvalid_q;
      rdata_d = rdata_q;
      rresp_d = rresp_q;
      if (s_axi_arvalid && arready_q) begin
         arready_d = 1'b0;
         rvalid_d = 1'b1;
         rresp_d = mie_pkg::RESP_OKAY;
         if (s_axi_araddr[7:mie_pkg::ADDR_LSB] ==
             mie_pkg::ADDR_ENABLE[7:mie_pkg::ADDR_LSB]) begin
            rdata_d = enable_q;
         end else if (s_axi_araddr[7:mie_pkg::ADDR_LSB] ==
                      mie_pkg::ADDR_STATUS[7:mie_pkg::ADDR_LSB]) begin
            rdata_d = status_view;
         end else begin
            rdata_d = 32'h0000_0000;
            rresp_d = mie_pkg::RESP_SLVERR;
         end
      end
      if (rvalid_q && s_axi_rready) begin
         rvalid_d = 1'b0;
         arready_d = 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         arready_q <= 1'b1;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= 2'h0;
      end else begin
         arready_q <= arready_d;
         rvalid_q <= rvalid_d;
         rdata_q <= rdata_d;
         rresp_q <= rresp_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Enable register and sticky status flags.
   always_comb begin
      enable_d = enable_q;
      if (do_write && awaddr_q[7:mie_pkg::ADDR_LSB] ==
          mie_pkg::ADDR_ENABLE[7:mie_pkg::ADDR_LSB]) begin
         enable_d = ((enable_q & ~byte_mask) | (wdata_q & byte_mask))
                    & mie_pkg::ENABLE_MASK;
      end
   end

   // Writing one to a status bit clears it; a new event in the same cycle
   // wins, and the enables never stop a flag from being recorded.
   generate
      for (genvar g = 0; g < mie_pkg::NUM_FLAGS; g++) begin : g_flag
         assign flag_clear[g] = do_write &&
            awaddr_q[7:mie_pkg::ADDR_LSB] ==
            mie_pkg::ADDR_STATUS[7:mie_pkg::ADDR_LSB] &&
            wdata_q[mie_pkg::FLAG_BIT[g]] &&
            byte_mask[mie_pkg::FLAG_BIT[g]];
         assign flags_d[g] = flag_event[g] ||
            (flags_q[g] && !flag_clear[g]);
      end
   endgenerate

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         enable_q <= mie_pkg::ENABLE_RESET;
         flags_q <= mie_pkg::FLAGS_RESET;
      end else begin
         enable_q <= enable_d;
         flags_q <= flags_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupt lines. The receive sources are gated by the transmit
   // master enable, as the register map defines them.
   assign tx_summary = flags_q[mie_pkg::FLAG_TX_UNDERFLOW] &&
                       enable_q[mie_pkg::BIT_TX_UNDERFLOW];

   always_comb begin
      tx_irq_d = enable_q[mie_pkg::BIT_TX_MASTER] && tx_summary;
      rx_irq_d = enable_q[mie_pkg::BIT_TX_MASTER] &&
         ((flags_q[mie_pkg::FLAG_CTRL_FRAME] &&
           enable_q[mie_pkg::BIT_CTRL_FRAME]) ||
          (flags_q[mie_pkg::FLAG_RX_BUS_ERROR] &&
           enable_q[mie_pkg::BIT_RX_BUS_ERROR]));
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         tx_irq_q <= 1'b0;
         rx_irq_q <= 1'b0;
      end else begin
         tx_irq_q <= tx_irq_d;
         rx_irq_q <= rx_irq_d;
      end
   end

   assign s_axi_awready = awready_q;
   assign s_axi_wready = wready_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
   assign tx_irq = tx_irq_q;
   assign rx_irq = rx_irq_q;

   ////////////////////////////////////////////////////////////////////////
   // Checks.
   property p_tx_underflow_masked;
      @(posedge clock) disable iff (sys_rst)
      !enable_q[mie_pkg::BIT_TX_UNDERFLOW] |=> !tx_irq_q;
   endproperty
   a_tx_underflow_masked: assert property (p_tx_underflow_masked)
      else $error("Tx line rose with underflow enable low.");

   property p_tx_follows_summary;
      @(posedge clock) disable iff (sys_rst)
      (enable_q[mie_pkg::BIT_TX_MASTER] && tx_summary) ##1
      (enable_q[mie_pkg::BIT_TX_MASTER] && tx_summary) |-> tx_irq_q [*1];
   endproperty
   a_tx_follows_summary: assert property (p_tx_follows_summary)
      else $error("Tx line low with master enable and summary set.");

   property p_master_off_quiet;
      @(posedge clock) disable iff (sys_rst)
      !enable_q[mie_pkg::BIT_TX_MASTER] |=> (!tx_irq_q && !rx_irq_q);
   endproperty
   a_master_off_quiet: assert property (p_master_off_quiet)
      else $error("Interrupt line rose with master enable low.");

   property p_ctrl_frame_raises_rx;
      @(posedge clock) disable iff (sys_rst)
      (flags_q[mie_pkg::FLAG_CTRL_FRAME] &&
       enable_q[mie_pkg::BIT_CTRL_FRAME] &&
       enable_q[mie_pkg::BIT_TX_MASTER]) |=> rx_irq_q;
   endproperty
   a_ctrl_frame_raises_rx: assert property (p_ctrl_frame_raises_rx)
      else $error("Control frame flag did not raise Rx line.");

   property p_rx_masked;
      @(posedge clock) disable iff (sys_rst)
      !(flags_q[mie_pkg::FLAG_CTRL_FRAME] &&
        enable_q[mie_pkg::BIT_CTRL_FRAME]) &&
      !(flags_q[mie_pkg::FLAG_RX_BUS_ERROR] &&
        enable_q[mie_pkg::BIT_RX_BUS_ERROR]) |=> !rx_irq_q;
   endproperty
   a_rx_masked: assert property (p_rx_masked)
      else $error("Rx line rose with no enabled receive flag.");

   property p_bus_error_raises_rx;
      @(posedge clock) disable iff (sys_rst)
      (flags_q[mie_pkg::FLAG_RX_BUS_ERROR] &&
       enable_q[mie_pkg::BIT_RX_BUS_ERROR] &&
       enable_q[mie_pkg::BIT_TX_MASTER]) |=> rx_irq_q;
   endproperty
   a_bus_error_raises_rx: assert property (p_bus_error_raises_rx)
      else $error("Bus error flag did not raise Rx line.");

   property p_event_recorded;
      @(posedge clock) disable iff (sys_rst)
      rx_bus_error_event && !enable_q[mie_pkg::BIT_RX_BUS_ERROR]
      |=> status_view[mie_pkg::BIT_RX_BUS_ERROR];
   endproperty
   a_event_recorded: assert property (p_event_recorded)
      else $error("Masked bus error event was not recorded.");

   property p_write_answered;
      @(posedge clock) disable iff (sys_rst)
      $rose(aw_have_q && w_have_q) |-> ##[0:1] s_axi_bvalid;
   endproperty
   a_write_answered: assert property (p_write_answered)
      else $error("Write response late.");

endmodule

// ==== mie_pkg.sv ====
// Package with the register map, field positions and reset values.
package mie_pkg;

   // Register byte offsets on the AXI4-Lite slave.
   localparam logic [7:0] ADDR_ENABLE = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int ADDR_LSB = 2;

   // Field positions shared by the enable and status registers.
   localparam int BIT_TX_UNDERFLOW = 17;
   localparam int BIT_TX_MASTER = 16;
   localparam int BIT_CTRL_FRAME = 14;
   localparam int BIT_RX_BUS_ERROR = 11;

   // Event sources that set sticky flags, in this order.
   localparam int NUM_FLAGS = 3;
   localparam int FLAG_TX_UNDERFLOW = 0;
   localparam int FLAG_CTRL_FRAME = 1;
   localparam int FLAG_RX_BUS_ERROR = 2;
   localparam int FLAG_BIT [0:NUM_FLAGS-1] = '{
      BIT_TX_UNDERFLOW, BIT_CTRL_FRAME, BIT_RX_BUS_ERROR};

   // Writable bits of the enable register; the rest read as zero.
   localparam logic [31:0] ENABLE_MASK = 32'h0003_4800;
   localparam logic [31:0] ENABLE_RESET = 32'h0000_0000;
   localparam logic [NUM_FLAGS-1:0] FLAGS_RESET = 3'h0;

   // AXI response codes.
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ==== mie_cpu_model.sv ====
// Model of the CPU side that takes the Tx and Rx interrupt lines.
`timescale 1ns/1ps

module mie_cpu_model (
   // Clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // Interrupt lines from the block
   input wire logic tx_irq,
   input wire logic rx_irq,
   // Number of interrupt entries seen on each line
   output int tx_entries,
   output int rx_entries
);
   logic tx_q;
   logic rx_q;

   // An entry is counted on each rising level, as an edge-sensitive core would.
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         tx_q <= 1'h0;
         rx_q <= 1'h0;
         tx_entries <= 0;
         rx_entries <= 0;
      end else begin
         tx_q <= tx_irq;
         rx_q <= rx_irq;
         if (tx_irq === 1'h1 && tx_q === 1'h0) tx_entries <= tx_entries + 1;
         if (rx_irq === 1'h1 && rx_q === 1'h0) rx_entries <= rx_entries + 1;
      end
   end
endmodule

// ==== mac_irq_enable_mask_bench.sv ====
// Self-checking bench for the interrupt enable and masking block.
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end

module mac_irq_enable_mask_bench;
   localparam logic [31:0] FLAGS = 32'h0002_4800;
   logic clock = 1'h0;
   logic sys_rst = 1'h1;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
   logic arvalid = 1'h0, rready = 1'h0;
   logic [31:0] wdata = 32'h0000_0000;
   logic [3:0] wstrb = 4'hF;
   logic awready, wready, bvalid, arready, rvalid, tx_irq, rx_irq;
   logic [1:0] bresp, rresp, r;
   logic [31:0] rdata, d, v;
   logic [2:0] ev = 3'h0;
   logic [31:0] m_en = 32'h0000_0000, m_fl = 32'h0000_0000;
   int num_errors = 0, n_compared = 0, tx_entries, rx_entries;

   always #25 clock = ~clock;

   mie_irq_enable DUT (.clock(clock), .sys_rst(sys_rst),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .tx_underflow_event(ev[0]), .ctrl_frame_event(ev[1]),
      .rx_bus_error_event(ev[2]), .tx_irq(tx_irq), .rx_irq(rx_irq));

   mie_cpu_model cpu (.clock(clock), .sys_rst(sys_rst), .tx_irq(tx_irq),
      .rx_irq(rx_irq), .tx_entries(tx_entries), .rx_entries(rx_entries));

   ////////////////////////////////////////////////////////////////////////////
   task wr(input logic [7:0] a, input logic [31:0] x, output logic [1:0] rs);
      @(posedge clock);
      awaddr <= a;
      wdata <= x;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do begin
         @(posedge clock);
         if (awvalid && awready) awvalid <= 1'h0;
         if (wvalid && wready) wvalid <= 1'h0;
      end while (!bvalid);
      rs = bresp;
      bready <= 1'h0;
   endtask

   task rd(input logic [7:0] a, output logic [31:0] x, output logic [1:0] rs);
      @(posedge clock);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do begin
         @(posedge clock);
         if (arvalid && arready) arvalid <= 1'h0;
      end while (!rvalid);
      x = rdata;
      rs = rresp;
      rready <= 1'h0;
   endtask

   // Events are one-cycle pulses; the model records them as sticky flags.
   task pulse(input logic [2:0] x);
      @(posedge clock);
      ev <= x;
      @(posedge clock);
      ev <= 3'h0;
      if (x[0]) m_fl[17] = 1'h1;
      if (x[1]) m_fl[14] = 1'h1;
      if (x[2]) m_fl[11] = 1'h1;
   endtask

   task set_en(input logic [31:0] x);
      wr(mie_pkg::ADDR_ENABLE, x, r);
      `CHK(r, mie_pkg::RESP_OKAY)
      m_en = x & mie_pkg::ENABLE_MASK;
   endtask

   task check_all;
      logic etx, erx;
      logic [31:0] es;
      repeat (3) @(posedge clock);
      etx = m_en[16] & m_en[17] & m_fl[17];
      erx = m_en[16] & ((m_en[14] & m_fl[14]) | (m_en[11] & m_fl[11]));
      es = m_fl;
      es[16] = m_fl[17] & m_en[17];
      `CHK(tx_irq, etx)
      `CHK(rx_irq, erx)
      rd(mie_pkg::ADDR_ENABLE, d, r);
      `CHK(d, m_en)
      rd(mie_pkg::ADDR_STATUS, d, r);
      `CHK(d, es)
      `CHK(r, mie_pkg::RESP_OKAY)
   endtask

   task wrap_up;
      $display("Compared %0d, errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge clock);
      num_errors++;
      wrap_up;
   end

   initial begin
      void'($urandom(49));
      repeat (8) @(posedge clock);
      sys_rst <= 1'h0;
      check_all;
      // Flags must be recorded while every enable is still off.
      pulse(3'h7);
      check_all;
      // Every combination of the four enables against all flags set.
      for (int i = 0; i < 16; i++) begin
         v = 32'h0000_0000;
         v[17] = i[3];
         v[16] = i[2];
         v[14] = i[1];
         v[11] = i[0];
         set_en(v);
         check_all;
      end
      // Unmapped places are refused and leave the enables alone.
      wr(8'h10, 32'hFFFF_FFFF, r);
      `CHK(r, mie_pkg::RESP_SLVERR)
      rd(8'h08, d, r);
      `CHK(d, 32'h0000_0000)
      `CHK(r, mie_pkg::RESP_SLVERR)
      check_all;
      wr(mie_pkg::ADDR_STATUS, 32'hFFFF_FFFF, r);
      m_fl = 32'h0000_0000;
      check_all;
      for (int i = 0; i < 40; i++) begin
         v = $urandom;
         case ($urandom % 3)
            0: set_en(v);
            1: pulse(v[2:0]);
            default: begin
               wr(mie_pkg::ADDR_STATUS, v, r);
               m_fl = m_fl & ~(v & FLAGS);
            end
         endcase
         check_all;
      end
      `CHK(tx_entries != 0, 1'h1)
      `CHK(rx_entries != 0, 1'h1)
      wrap_up;
   end
endmodule
